// ### verilog/atp_regs.svh
// Field positions, codes and sizes of the asynchronous transmit packet formatter
// Overview of operation
// - Speed field 00/01/10 selects rate; 11 illegal
// - Retry field only first attempt or continued
// - Response code 0,4-7 valid; rest reserved
// - Host labels requests; responses echo the label
// - Quadlets two, three: node id, offset/response
// - Fourth quadlet: data, or read byte count
// - Block: byte count plus lock code, else zero
// - Block responses carry response code, not offset
// - Payload follows count quadlet, count gives bytes
// - Zero byte count means no payload quadlets
// - First payload byte in top byte
// - Final partial quadlet padded with zero bytes
// - Unformatted quadlets sent exactly as queued
// - Unformatted: no CRC, control quadlet dropped
// - Host queues inverted check quadlet itself
// - Transaction code selects the transmit format
// - Host writes zeros into reserved fields
`ifndef ATP_REGS_SVH
`define ATP_REGS_SVH
`define ATP_SPD_LSB    5'd16
`define ATP_LBL_LSB    5'd10
`define ATP_RT_LSB     5'd8
`define ATP_TC_LSB     5'd4
`define ATP_RCODE_LSB  5'd12
`define ATP_CNT_LSB    5'd16
`define ATP_SPD_BAD    2'h3
`define ATP_RT_FIRST   2'h0
`define ATP_RT_CONT    2'h1
`define ATP_RC_OK      4'h0
`define ATP_RC_LO      4'h4
`define ATP_RC_HI      4'h7
`define ATP_FIFO_DEPTH 16
`define ATP_HDR_NODATA 2'h2
`define ATP_HDR_FULL   2'h3
`endif

// ### verilog/atp_pkg.sv
// Types shared by both ends of the transmit queue
package atp_pkg;
   typedef enum logic [3:0] {
      TC_QWRITE_REQ = 4'h0,
      TC_BWRITE_REQ = 4'h1,
      TC_WRITE_RSP  = 4'h2,
      TC_QREAD_REQ  = 4'h4,
      TC_BREAD_REQ  = 4'h5,
      TC_QREAD_RSP  = 4'h6,
      TC_BREAD_RSP  = 4'h7,
      TC_LOCK_REQ   = 4'h9,
      TC_LOCK_RSP   = 4'hb,
      TC_UNFORMAT   = 4'he
   } atp_tcode_t;
   typedef enum logic [1:0] {
      SPD_100 = 2'h0,
      SPD_200 = 2'h1,
      SPD_400 = 2'h2
   } atp_speed_t;
   typedef enum logic [2:0] {
      D_CTRL = 3'h0,
      D_HDR  = 3'h1,
      D_PAY  = 3'h2,
      D_RAW  = 3'h3,
      D_DROP = 3'h4
   } atp_dev_state_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_CTRL = 3'h1,
      H_Q2   = 3'h2,
      H_Q3   = 3'h3,
      H_Q4   = 3'h4,
      H_PAY  = 3'h5,
      H_RAW  = 3'h6,
      H_INV  = 3'h7
   } atp_host_state_t;
endpackage

// ### verilog/atp_queue_if.sv
// Transmit queue link between host end and device end
`timescale 1ns/1ns
`default_nettype none
interface atp_queue_if;
   logic        q_valid;
   logic        q_ready;
   logic [31:0] q_data;
   logic        q_last;
   modport host (output q_valid, output q_data, output q_last, input q_ready);
   modport dev  (input q_valid, input q_data, input q_last, output q_ready);
endinterface
`default_nettype wire

// ### verilog/atp_device.sv
// Device end: queue FIFO and transmit packet formatter
`timescale 1ns/1ns
`default_nettype none
`include "atp_regs.svh"

module atp_fifo #(
   parameter int W = 33,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          push, pop;

   assign in_ready  = (cnt_r != D[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_r];

   always_comb begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      wr_nxt  = push ? ((wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1) : wr_r;
      rd_nxt  = pop ? ((rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1) : rd_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end
endmodule // atp_fifo

module atp_device #(
   parameter int DEPTH = `ATP_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   reset,
   // Transmit queue from host
   atp_queue_if.dev    q,
   // Towards the physical layer
   output logic        tx_valid,
   input  wire logic   tx_ready,
   output logic [31:0] tx_data,
   output logic        tx_first,
   output logic        tx_last,
   output logic        tx_crc,
   output logic [1:0]  tx_speed,
   // Malformed packet seen
   output logic        bad_packet
);
   atp_pkg::atp_dev_state_t state_r, state_nxt;
   logic [1:0]  hidx_r, hidx_nxt, hlast_r, hlast_nxt;
   logic [13:0] qleft_r, qleft_nxt;
   logic [1:0]  tail_r, tail_nxt;
   logic        blk_r, blk_nxt, rsp_r, rsp_nxt;
   logic        txv_r, txv_nxt, first_r, first_nxt, last_r, last_nxt, crc_r, crc_nxt, bad_r, bad_nxt;
   logic [31:0] txd_r, txd_nxt;
   logic [1:0]  spd_r, spd_nxt;
   logic        f_valid, f_ready, adv, pop;
   logic [32:0] f_data;
   logic [31:0] d;
   logic [3:0]  tc, rc;
   logic [1:0]  sp, rt;
   logic [15:0] bcnt;

   atp_fifo #(.W(33), .D(DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (q.q_valid),
      .in_ready  (q.q_ready),
      .in_data   ({q.q_last, q.q_data}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   always_comb begin
      adv       = !txv_r || tx_ready;
      f_ready   = adv;
      pop       = f_valid && adv;
      d         = f_data[31:0];
      tc        = d[`ATP_TC_LSB +: 4];
      sp        = d[`ATP_SPD_LSB +: 2];
      rt        = d[`ATP_RT_LSB +: 2];
      rc        = d[`ATP_RCODE_LSB +: 4];
      bcnt      = d[`ATP_CNT_LSB +: 16];
      state_nxt = state_r;
      hidx_nxt  = hidx_r;
      hlast_nxt = hlast_r;
      qleft_nxt = qleft_r;
      tail_nxt  = tail_r;
      blk_nxt   = blk_r;
      rsp_nxt   = rsp_r;
      spd_nxt   = spd_r;
      txv_nxt   = txv_r && !tx_ready;
      txd_nxt   = txd_r;
      first_nxt = first_r;
      last_nxt  = last_r;
      crc_nxt   = crc_r;
      bad_nxt   = 1'b0;
      if (pop) begin
         unique case (state_r)
            atp_pkg::D_CTRL: begin
               hidx_nxt = 2'h1;
               spd_nxt  = sp;
               rsp_nxt  = 1'b0;
               blk_nxt  = 1'b0;
               if (sp == `ATP_SPD_BAD || (rt != `ATP_RT_FIRST && rt != `ATP_RT_CONT)) begin
                  bad_nxt   = 1'b1;
                  state_nxt = f_data[32] ? atp_pkg::D_CTRL : atp_pkg::D_DROP;
               end else begin
                  // Format chosen by transaction code
                  case (tc)
                     atp_pkg::TC_QREAD_REQ, atp_pkg::TC_WRITE_RSP: begin
                        hlast_nxt = `ATP_HDR_NODATA;
                        rsp_nxt   = (tc == atp_pkg::TC_WRITE_RSP);
                        state_nxt = atp_pkg::D_HDR;
                     end
                     atp_pkg::TC_QWRITE_REQ, atp_pkg::TC_QREAD_RSP, atp_pkg::TC_BREAD_REQ: begin
                        hlast_nxt = `ATP_HDR_FULL;
                        rsp_nxt   = (tc == atp_pkg::TC_QREAD_RSP);
                        state_nxt = atp_pkg::D_HDR;
                     end
                     atp_pkg::TC_BWRITE_REQ, atp_pkg::TC_BREAD_RSP, atp_pkg::TC_LOCK_REQ,
                     atp_pkg::TC_LOCK_RSP: begin
                        hlast_nxt = `ATP_HDR_FULL;
                        blk_nxt   = 1'b1;
                        rsp_nxt   = (tc == atp_pkg::TC_BREAD_RSP) || (tc == atp_pkg::TC_LOCK_RSP);
                        state_nxt = atp_pkg::D_HDR;
                     end
                     atp_pkg::TC_UNFORMAT: begin
                        hidx_nxt  = 2'h0;
                        state_nxt = f_data[32] ? atp_pkg::D_CTRL : atp_pkg::D_RAW;
                     end
                     default: begin
                        bad_nxt   = 1'b1;
                        state_nxt = f_data[32] ? atp_pkg::D_CTRL : atp_pkg::D_DROP;
                     end
                  endcase
                  if (tc != atp_pkg::TC_UNFORMAT && state_nxt == atp_pkg::D_HDR) begin
                     // Control quadlet opens the formatted header
                     txv_nxt   = 1'b1;
                     txd_nxt   = d;
                     first_nxt = 1'b1;
                     last_nxt  = 1'b0;
                     crc_nxt   = 1'b1;
                  end
               end
            end
            atp_pkg::D_HDR: begin
               txv_nxt   = 1'b1;
               txd_nxt   = d;
               first_nxt = 1'b0;
               last_nxt  = 1'b0;
               hidx_nxt  = hidx_r + 2'h1;
               if (hidx_r == 2'h1 && rsp_r && !(rc == `ATP_RC_OK || (rc >= `ATP_RC_LO && rc <= `ATP_RC_HI))) begin
                  bad_nxt = 1'b1;
               end
               if (hidx_r == hlast_r) begin
                  if (blk_r && bcnt != 16'h0) begin
                     qleft_nxt = 14'((17'(bcnt) + 17'h3) >> 2);
                     tail_nxt  = bcnt[1:0];
                     state_nxt = atp_pkg::D_PAY;
                  end else begin
                     last_nxt  = 1'b1;
                     state_nxt = atp_pkg::D_CTRL;
                  end
               end
            end
            atp_pkg::D_PAY: begin
               txv_nxt   = 1'b1;
               txd_nxt   = d;
               first_nxt = 1'b0;
               last_nxt  = (qleft_r == 14'h1);
               qleft_nxt = qleft_r - 14'h1;
               if (qleft_r == 14'h1) begin
                  // Clear bytes past the count in the final quadlet
                  unique case (tail_r)
                     2'h1:    txd_nxt = {d[31:24], 24'h0};
                     2'h2:    txd_nxt = {d[31:16], 16'h0};
                     2'h3:    txd_nxt = {d[31:8], 8'h0};
                     2'h0:    txd_nxt = d;
                  endcase
                  state_nxt = atp_pkg::D_CTRL;
               end
            end
            atp_pkg::D_RAW: begin
               txv_nxt   = 1'b1;
               txd_nxt   = d;
               first_nxt = (hidx_r == 2'h0);
               hidx_nxt  = 2'h1;
               last_nxt  = f_data[32];
               crc_nxt   = 1'b0;
               if (f_data[32]) begin
                  state_nxt = atp_pkg::D_CTRL;
               end
            end
            atp_pkg::D_DROP: begin
               if (f_data[32]) begin
                  state_nxt = atp_pkg::D_CTRL;
               end
            end
            default: state_nxt = atp_pkg::D_CTRL;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= atp_pkg::D_CTRL;
         hidx_r  <= 2'h0;
         hlast_r <= 2'h0;
         qleft_r <= 14'h0;
         tail_r  <= 2'h0;
         blk_r   <= 1'b0;
         rsp_r   <= 1'b0;
         spd_r   <= 2'h0;
         txv_r   <= 1'b0;
         txd_r   <= 32'h0;
         first_r <= 1'b0;
         last_r  <= 1'b0;
         crc_r   <= 1'b0;
         bad_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         hidx_r  <= hidx_nxt;
         hlast_r <= hlast_nxt;
         qleft_r <= qleft_nxt;
         tail_r  <= tail_nxt;
         blk_r   <= blk_nxt;
         rsp_r   <= rsp_nxt;
         spd_r   <= spd_nxt;
         txv_r   <= txv_nxt;
         txd_r   <= txd_nxt;
         first_r <= first_nxt;
         last_r  <= last_nxt;
         crc_r   <= crc_nxt;
         bad_r   <= bad_nxt;
      end
   end

   assign tx_valid   = txv_r;
   assign tx_data    = txd_r;
   assign tx_first   = first_r;
   assign tx_last    = last_r;
   assign tx_crc     = crc_r;
   assign tx_speed   = spd_r;
   assign bad_packet = bad_r;
endmodule // atp_device
`default_nettype wire

// ### verilog/atp_host.sv
// Host end: builds transmit queue quadlets from packet commands
`timescale 1ns/1ns
`default_nettype none
`include "atp_regs.svh"

module atp_host (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Packet command
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [3:0]  cmd_tcode,
   input  wire logic [1:0]  cmd_speed,
   input  wire logic [1:0]  cmd_retry_kind,
   input  wire logic [5:0]  cmd_label,
   input  wire logic [15:0] cmd_dest_id,
   input  wire logic [47:0] cmd_offset,
   input  wire logic [3:0]  cmd_rcode,
   input  wire logic [31:0] cmd_quadlet,
   input  wire logic [15:0] cmd_payload_byte_count,
   input  wire logic [15:0] cmd_lock_operation_code,
   // Payload or unformatted words
   input  wire logic        pay_valid,
   output logic             pay_ready,
   input  wire logic [31:0] pay_data,
   input  wire logic        pay_last,
   // Transmit queue to device
   atp_queue_if.host        q
);
   atp_pkg::atp_host_state_t state_r, state_nxt;
   logic [3:0]  tc_r, tc_nxt, rc_r, rc_nxt;
   logic [1:0]  spd_r, spd_nxt, rt_r, rt_nxt;
   logic [5:0]  lbl_r, lbl_nxt;
   logic [15:0] dst_r, dst_nxt, cnt_r, cnt_nxt, lock_r, lock_nxt;
   logic [47:0] off_r, off_nxt;
   logic [31:0] qd_r, qd_nxt, qv_d_r, qv_d_nxt;
   logic [13:0] left_r, left_nxt;
   logic        raw_last_r, raw_last_nxt;
   logic        qv_r, qv_nxt, ql_r, ql_nxt, cr_r, cr_nxt, pr_r, pr_nxt;
   logic        free, rsp, blk, lock;

   always_comb begin
      free     = !qv_r || q.q_ready;
      rsp      = (tc_r == atp_pkg::TC_WRITE_RSP) || (tc_r == atp_pkg::TC_QREAD_RSP) ||
                 (tc_r == atp_pkg::TC_BREAD_RSP) || (tc_r == atp_pkg::TC_LOCK_RSP);
      lock     = (tc_r == atp_pkg::TC_LOCK_REQ) || (tc_r == atp_pkg::TC_LOCK_RSP);
      blk      = lock || (tc_r == atp_pkg::TC_BWRITE_REQ) || (tc_r == atp_pkg::TC_BREAD_RSP);
      state_nxt = state_r;
      tc_nxt   = tc_r;
      rc_nxt   = rc_r;
      spd_nxt  = spd_r;
      rt_nxt   = rt_r;
      lbl_nxt  = lbl_r;
      dst_nxt  = dst_r;
      cnt_nxt  = cnt_r;
      lock_nxt = lock_r;
      off_nxt  = off_r;
      qd_nxt   = qd_r;
      left_nxt = left_r;
      raw_last_nxt = raw_last_r;
      qv_nxt   = qv_r && !q.q_ready;
      qv_d_nxt = qv_d_r;
      ql_nxt   = ql_r;
      unique case (state_r)
         atp_pkg::H_IDLE: begin
            if (cmd_valid && cr_r) begin
               tc_nxt    = cmd_tcode;
               spd_nxt   = cmd_speed;
               rt_nxt    = cmd_retry_kind;
               lbl_nxt   = cmd_label;
               dst_nxt   = cmd_dest_id;
               off_nxt   = cmd_offset;
               rc_nxt    = cmd_rcode;
               qd_nxt    = cmd_quadlet;
               cnt_nxt   = cmd_payload_byte_count;
               lock_nxt  = cmd_lock_operation_code;
               state_nxt = atp_pkg::H_CTRL;
            end
         end
         atp_pkg::H_CTRL: begin
            if (free) begin
               qv_nxt   = 1'b1;
               qv_d_nxt = 32'h0;
               qv_d_nxt[`ATP_SPD_LSB +: 2] = spd_r;
               qv_d_nxt[`ATP_LBL_LSB +: 6] = lbl_r;
               qv_d_nxt[`ATP_RT_LSB +: 2]  = rt_r;
               qv_d_nxt[`ATP_TC_LSB +: 4]  = tc_r;
               ql_nxt   = 1'b0;
               state_nxt = (tc_r == atp_pkg::TC_UNFORMAT) ? atp_pkg::H_RAW : atp_pkg::H_Q2;
            end
         end
         atp_pkg::H_Q2: begin
            if (free) begin
               qv_nxt   = 1'b1;
               qv_d_nxt = rsp ? {dst_r, rc_r, 12'h0} : {dst_r, off_r[47:32]};
               state_nxt = atp_pkg::H_Q3;
            end
         end
         atp_pkg::H_Q3: begin
            if (free) begin
               qv_nxt   = 1'b1;
               qv_d_nxt = rsp ? 32'h0 : {off_r[31:2], 2'h0};
               ql_nxt   = (tc_r == atp_pkg::TC_QREAD_REQ) || (tc_r == atp_pkg::TC_WRITE_RSP);
               state_nxt = ql_nxt ? atp_pkg::H_IDLE : atp_pkg::H_Q4;
            end
         end
         atp_pkg::H_Q4: begin
            if (free) begin
               qv_nxt   = 1'b1;
               if (blk) begin
                  qv_d_nxt = {cnt_r, lock ? lock_r : 16'h0};
               end else if (tc_r == atp_pkg::TC_BREAD_REQ) begin
                  qv_d_nxt = {cnt_r, 16'h0};
               end else begin
                  qv_d_nxt = qd_r;
               end
               left_nxt = 14'((17'(cnt_r) + 17'h3) >> 2);
               ql_nxt   = !blk || cnt_r == 16'h0;
               state_nxt = ql_nxt ? atp_pkg::H_IDLE : atp_pkg::H_PAY;
            end
         end
         atp_pkg::H_PAY: begin
            if (pay_valid && pr_r) begin
               qv_nxt   = 1'b1;
               qv_d_nxt = pay_data;
               left_nxt = left_r - 14'h1;
               ql_nxt   = (left_r == 14'h1);
               if (left_r == 14'h1) begin
                  unique case (cnt_r[1:0])
                     2'h1: qv_d_nxt = {pay_data[31:24], 24'h0};
                     2'h2: qv_d_nxt = {pay_data[31:16], 16'h0};
                     2'h3: qv_d_nxt = {pay_data[31:8], 8'h0};
                     2'h0: qv_d_nxt = pay_data;
                  endcase
                  state_nxt = atp_pkg::H_IDLE;
               end
            end
         end
         atp_pkg::H_RAW: begin
            if (pay_valid && pr_r) begin
               qv_nxt       = 1'b1;
               qv_d_nxt     = pay_data;
               ql_nxt       = 1'b0;
               raw_last_nxt = pay_last;
               state_nxt    = atp_pkg::H_INV;
            end
         end
         atp_pkg::H_INV: begin
            if (free) begin
               qv_nxt    = 1'b1;
               qv_d_nxt  = ~qv_d_r;
               ql_nxt    = raw_last_r;
               state_nxt = raw_last_r ? atp_pkg::H_IDLE : atp_pkg::H_RAW;
            end
         end
      endcase
      cr_nxt = (state_nxt == atp_pkg::H_IDLE) && !(state_r == atp_pkg::H_IDLE && cmd_valid && cr_r);
      pr_nxt = (state_nxt == atp_pkg::H_PAY || state_nxt == atp_pkg::H_RAW) && !qv_nxt;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r    <= atp_pkg::H_IDLE;
         tc_r       <= 4'h0;
         rc_r       <= 4'h0;
         spd_r      <= 2'h0;
         rt_r       <= 2'h0;
         lbl_r      <= 6'h0;
         dst_r      <= 16'h0;
         cnt_r      <= 16'h0;
         lock_r     <= 16'h0;
         off_r      <= 48'h0;
         qd_r       <= 32'h0;
         left_r     <= 14'h0;
         raw_last_r <= 1'b0;
         qv_r       <= 1'b0;
         qv_d_r     <= 32'h0;
         ql_r       <= 1'b0;
         cr_r       <= 1'b0;
         pr_r       <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         tc_r       <= tc_nxt;
         rc_r       <= rc_nxt;
         spd_r      <= spd_nxt;
         rt_r       <= rt_nxt;
         lbl_r      <= lbl_nxt;
         dst_r      <= dst_nxt;
         cnt_r      <= cnt_nxt;
         lock_r     <= lock_nxt;
         off_r      <= off_nxt;
         qd_r       <= qd_nxt;
         left_r     <= left_nxt;
         raw_last_r <= raw_last_nxt;
         qv_r       <= qv_nxt;
         qv_d_r     <= qv_d_nxt;
         ql_r       <= ql_nxt;
         cr_r       <= cr_nxt;
         pr_r       <= pr_nxt;
      end
   end

   assign cmd_ready = cr_r;
   assign pay_ready = pr_r;
   assign q.q_valid = qv_r;
   assign q.q_data  = qv_d_r;
   assign q.q_last  = ql_r;
endmodule // atp_host
`default_nettype wire

// ### verification/atp_queue_chk.sv
// Checker on the transmit queue link between host end and device end
`timescale 1ns/1ns
`default_nettype none
module atp_queue_chk (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Queue link
   input wire logic        q_valid,
   input wire logic        q_ready,
   input wire logic [31:0] q_data,
   input wire logic        q_last
);
   logic [7:0]  idx_r, idx_nxt, end_idx;
   logic [3:0]  tc_r, tc_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [31:0] prv_r, prv_nxt;
   logic        acc, blk, rsp;
   assign acc = q_valid && q_ready;
   assign blk = tc_r inside {4'h1, 4'h7, 4'h9, 4'hb};
   assign rsp = tc_r inside {4'h2, 4'h6, 4'h7, 4'hb};
   assign end_idx = 8'h3 + 8'((cnt_r + 16'h3) >> 2);
   // Word position within the packet and fields kept from it
   always_comb begin
      idx_nxt = idx_r;
      tc_nxt = tc_r;
      cnt_nxt = cnt_r;
      prv_nxt = acc ? q_data : prv_r;
      if (acc) begin
         idx_nxt = q_last ? 8'h0 : idx_r + 8'h1;
         if (idx_r == 8'h0) tc_nxt = q_data[7:4];
         if (idx_r == 8'h3) cnt_nxt = q_data[31:16];
      end
   end
   always_ff @(posedge core_clk) begin
      idx_r <= reset ? 8'h0 : idx_nxt;
      tc_r <= reset ? 4'h0 : tc_nxt;
      cnt_r <= reset ? 16'h0 : cnt_nxt;
      prv_r <= reset ? 32'h0 : prv_nxt;
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   sequence stall_s;
      q_valid && !q_ready;
   endsequence
   sequence ctrl_s;
      acc && idx_r == 8'h0;
   endsequence
   chk_offer_held: assert property (
      stall_s |=> q_valid && $stable(q_data) && $stable(q_last)) else $error("offer changed while stalled");
   chk_ctrl_reserved: assert property (
      ctrl_s |-> q_data[31:18] == 14'h0 && q_data[3:0] == 4'h0) else $error("control reserved bits set");
   chk_offset_align: assert property (
      acc && idx_r == 8'h2 && !rsp && tc_r != 4'he |-> q_data[1:0] == 2'h0) else $error("offset not aligned");
   chk_resp_fields: assert property (
      acc && rsp && idx_r == 8'h2 |-> q_data == 32'h0 && prv_r[11:0] == 12'h0) else $error("response fields");
   chk_nodata_len: assert property (
      acc && idx_r != 8'h0 && tc_r inside {4'h2, 4'h4} |-> q_last == (idx_r == 8'h2)) else $error("no-data length");
   chk_quad_len: assert property (
      acc && idx_r != 8'h0 && tc_r inside {4'h0, 4'h5, 4'h6} |-> q_last == (idx_r == 8'h3)) else $error("quad length");
   chk_block_len: assert property (
      acc && blk && idx_r == 8'h3 |-> q_last == (q_data[31:16] == 16'h0)) else $error("empty block length");
   chk_pay_end: assert property (
      acc && blk && idx_r > 8'h3 |-> q_last == (idx_r == end_idx)) else $error("payload length");
   chk_pad_zero: assert property (
      acc && blk && q_last && idx_r > 8'h3 && cnt_r[1:0] != 2'h0
      |-> (q_data & (32'hffffffff >> {cnt_r[1:0], 3'h0})) == 32'h0) else $error("padding not zero");
   chk_check_quad: assert property (
      acc && tc_r == 4'he && idx_r != 8'h0 && !idx_r[0] |-> q_data == ~prv_r) else $error("check quadlet");
endmodule // atp_queue_chk
`default_nettype wire

// ### verification/tb_async_transmit_packet_formatter.sv
// Bench joining host end and device end through the queue link
`timescale 1ns/1ns
`default_nettype none
module tb_async_transmit_packet_formatter;
   logic        core_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, hold_tx = 1'b0, pay_acc = 1'b0;
   logic        cmd_ready, pay_ready, tx_valid, tx_first, tx_last, tx_crc, bad_packet;
   logic        pay_valid = 1'b0, pay_last = 1'b0, tx_ready = 1'b0;
   logic [3:0]  cmd_tcode = 4'h0, cmd_rcode = 4'h0;
   logic [1:0]  cmd_speed = 2'h0, cmd_retry_kind = 2'h0, tx_speed;
   logic [5:0]  cmd_label = 6'h0;
   logic [15:0] cmd_dest_id = 16'hffc1, cmd_payload_byte_count = 16'h0, cmd_lock_operation_code = 16'h0002;
   logic [47:0] cmd_offset = 48'h0123_4567_89ab;
   logic [31:0] cmd_quadlet = 32'hcafe_f00d, pay_data = 32'h0, tx_data;
   logic [36:0] exp_q[$], got_q[$];
   logic [32:0] pay_q[$];
   int          err_total = 0, num_checks = 0, bad_n = 0, cyc = 0, t;
   atp_queue_if q_link ();
   atp_host atp_host_inst (.core_clk, .reset, .cmd_valid, .cmd_ready, .cmd_tcode, .cmd_speed, .cmd_retry_kind,
      .cmd_label, .cmd_dest_id, .cmd_offset, .cmd_rcode, .cmd_quadlet, .cmd_payload_byte_count,
      .cmd_lock_operation_code, .pay_valid, .pay_ready, .pay_data, .pay_last, .q(q_link));
   atp_device atp_device_inst (.core_clk, .reset, .q(q_link), .tx_valid, .tx_ready, .tx_data, .tx_first,
      .tx_last, .tx_crc, .tx_speed, .bad_packet);
   atp_queue_chk atp_queue_chk_inst (.core_clk, .reset, .q_valid(q_link.q_valid), .q_ready(q_link.q_ready),
      .q_data(q_link.q_data), .q_last(q_link.q_last));
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   // Payload feeder; an idle data line toggles
   always @(posedge core_clk) pay_acc <= pay_valid && pay_ready;
   always @(negedge core_clk) begin
      if (pay_acc && pay_q.size() > 0) void'(pay_q.pop_front());
      pay_valid = pay_q.size() > 0;
      pay_data = pay_valid ? pay_q[0][31:0] : ~pay_data;
      pay_last = pay_valid && pay_q[0][32];
      cyc++;
      tx_ready = !hold_tx && (cyc % 3 != 0);
   end
   always @(posedge core_clk) begin
      if (!reset && tx_valid && tx_ready) got_q.push_back({tx_speed, tx_first, tx_last, tx_crc, tx_data});
      if (!reset && bad_packet === 1'b1) bad_n++;
   end
   task automatic check(input string what, input logic [36:0] seen, input logic [36:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic test_done();
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic send(input logic [3:0] tc, input logic [1:0] sp, input logic [1:0] rt,
                       input logic [3:0] rc, input logic [15:0] n, input bit ok);
      logic [31:0] w[$];
      logic [31:0] d;
      logic        rsp, blk;
      int          i, k, u;
      rsp = tc inside {4'h2, 4'h6, 4'h7, 4'hb};
      blk = tc inside {4'h1, 4'h7, 4'h9, 4'hb};
      k = (tc == 4'he) ? n : blk ? (n + 3) / 4 : 0;
      if (tc != 4'he) begin
         w.push_back({14'h0, sp, tc, sp, rt, tc, 4'h0});
         w.push_back({cmd_dest_id, rsp ? {rc, 12'h0} : cmd_offset[47:32]});
         w.push_back(rsp ? 32'h0 : {cmd_offset[31:2], 2'h0});
         if (tc inside {4'h0, 4'h6}) w.push_back(cmd_quadlet);
         if (tc == 4'h5) w.push_back({n, 16'h0});
         if (blk) w.push_back({n, tc[3] ? cmd_lock_operation_code : 16'h0});
      end
      for (i = 0; i < k; i++) begin
         d = {8'ha0 + i[7:0], 24'h5a5a5a};
         pay_q.push_back({i == k - 1, d});
         if (tc == 4'he) w.push_back(d);
         if (tc == 4'he) d = ~d;
         else if (i == k - 1 && n[1:0] != 2'h0) d = d & ~(32'hffffffff >> {n[1:0], 3'h0});
         w.push_back(d);
      end
      if (ok) for (i = 0; i < w.size(); i++) exp_q.push_back({sp, i == 0, i == w.size() - 1, tc != 4'he, w[i]});
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_tcode = tc;
      cmd_speed = sp;
      cmd_retry_kind = rt;
      cmd_rcode = rc;
      cmd_label = {tc, sp};
      cmd_payload_byte_count = n;
      u = 0;
      do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++u < 300);
      check("cmd", 37'(cmd_ready), 37'h1);
      @(negedge core_clk);
      cmd_valid = 1'b0;
   endtask
   task automatic flush();
      for (t = 0; t < 3000 && got_q.size() < exp_q.size(); t++) @(posedge core_clk);
      repeat (40) @(posedge core_clk);
      check("tx count", 37'(got_q.size()), 37'(exp_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0) check("tx word", got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
   endtask
   initial begin
      #40000;
      err_total++;
      test_done();
   end
   initial begin
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      send(4'h4, 2'h0, 2'h0, 4'h0, 16'h0, 1);
      send(4'h2, 2'h1, 2'h1, 4'h4, 16'h0, 1);
      send(4'h0, 2'h2, 2'h0, 4'h0, 16'h0, 1);
      send(4'h6, 2'h0, 2'h1, 4'h5, 16'h0, 1);
      send(4'h5, 2'h1, 2'h0, 4'h0, 16'h40, 1);
      send(4'h1, 2'h2, 2'h1, 4'h0, 16'h5, 1);
      send(4'h7, 2'h0, 2'h0, 4'h6, 16'h0, 1);
      send(4'h9, 2'h1, 2'h0, 4'h0, 16'h8, 1);
      send(4'hb, 2'h2, 2'h1, 4'h7, 16'h3, 1);
      send(4'he, 2'h1, 2'h0, 4'h0, 16'h2, 1);
      flush();
      send(4'h0, 2'h3, 2'h0, 4'h0, 16'h0, 0);
      send(4'h0, 2'h0, 2'h2, 4'h0, 16'h0, 0);
      send(4'h2, 2'h0, 2'h0, 4'h1, 16'h0, 1);
      send(4'h3, 2'h0, 2'h0, 4'h0, 16'h0, 0);
      flush();
      check("bad packets", 37'(bad_n), 37'h4);
      hold_tx = 1'b1;
      send(4'h1, 2'h0, 2'h0, 4'h0, 16'h50, 1);
      for (t = 0; t < 400 && q_link.q_ready !== 1'b0; t++) @(posedge core_clk);
      check("queue full", 37'(q_link.q_ready), 37'h0);
      hold_tx <= 1'b0;
      flush();
      test_done();
   end
endmodule // tb_async_transmit_packet_formatter
`default_nettype wire
